// [logic/apc_acq_ctrl.sv]
// What this block does
// R01 - oversample field selects ratio two to the n, interval 6 to 512 ms
// R02 - load bit set captures next pressure and temperature output as targets
// R03 - host clears then sets load bit again for a fresh capture
// R04 - host sets load bit once before using captured targets
// R05 - source bit picks programmed targets (0) or captured readings (1)
// R06 - interval exponent bits 3..0 give acquisition step two to n seconds
// R07 - pin A polarity bit 5, zero active low, one active high
// R08 - pin A drive bit 4, zero push-pull, one open drain
// R09 - pin B polarity bit 1, zero active low, one active high
// R10 - pin B drive bit 0, zero push-pull, one open drain
// R11 - reserved bits are read-only and read zero
// R12 - oversample field is bits 5..3 of sampling control, reset 000
// R13 - all routed sources per pin are ORed before polarity and drive
// R14 - open drain pins drive only when active, else released
module apc_acq_ctrl (
	input  wire logic        clock,
	input  wire logic        reset_n,
	// register port behind the serial interface
	input  wire logic        reg_write,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// measurement side
	input  wire logic        sample_valid,
	input  wire logic [19:0] pressure_output,
	input  wire logic [11:0] temperature_output,
	input  wire logic [19:0] pressure_target_prog,
	input  wire logic [11:0] temperature_target_prog,
	output logic      [19:0] pressure_target,
	output logic      [11:0] temperature_target,
	output logic      [2:0]  oversample_ratio_select,
	output logic      [7:0]  oversample_ratio,
	output logic      [9:0]  min_sample_interval_ms,
	output logic             sample_slot_ready,
	output logic             acquisition_tick,
	// routed interrupt sources, already enabled
	input  wire logic [7:0]  irq_sources_a,
	input  wire logic [7:0]  irq_sources_b,
	output logic             irq_pin_a_out,
	output logic             irq_pin_a_oe,
	output logic             irq_pin_b_out,
	output logic             irq_pin_b_oe
);
	import apc_pkg::*;

	// ****************************************************
	// registers
	// ****************************************************
	logic [7:0]     sampling_reg, sampling_next;
	logic [7:0]     acq_reg, acq_next;
	logic [7:0]     irq_reg, irq_next;
	logic [7:0]     rdata_next;

	// masked write keeps reserved bits at zero
	function automatic logic [7:0] masked(input logic [7:0] d,
		input logic [7:0] m);
		return d & m;
	endfunction

	always_comb begin
		sampling_next = sampling_reg;
		acq_next      = acq_reg;
		irq_next      = irq_reg;
		// R11 reserved read zero
		if (reg_write && reg_addr == SAMPLING_MODE_CONTROL_ADDR) begin
			sampling_next = masked(reg_wdata, SAMPLING_WRITE_MASK);
		end else if (reg_write &&
			reg_addr == ACQUISITION_ALARM_CONTROL_ADDR) begin
			acq_next = masked(reg_wdata, ACQ_WRITE_MASK);
		end else if (reg_write && reg_addr == IRQ_PIN_CONTROL_ADDR) begin
			irq_next = masked(reg_wdata, IRQ_WRITE_MASK);
		end
		// unmapped reads return zero
		if (reg_addr == SAMPLING_MODE_CONTROL_ADDR) begin
			rdata_next = sampling_next;
		end else if (reg_addr == ACQUISITION_ALARM_CONTROL_ADDR) begin
			rdata_next = acq_next;
		end else if (reg_addr == IRQ_PIN_CONTROL_ADDR) begin
			rdata_next = irq_next;
		end else begin
			rdata_next = 8'h00;
		end
	end

	// R12 oversample reset value
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sampling_reg <= CTRL_RESET;
			acq_reg      <= CTRL_RESET;
			irq_reg      <= CTRL_RESET;
			reg_rdata    <= 8'h00;
		end else begin
			sampling_reg <= sampling_next;
			acq_reg      <= acq_next;
			irq_reg      <= irq_next;
			reg_rdata    <= rdata_next;
		end
	end

	// ****************************************************
	// oversampling decode
	// ****************************************************
	// R01 ratio and interval
	always_comb begin
		oversample_ratio_select = sampling_reg[OSR_LSB +: 3];
		oversample_ratio        = 8'h01 << oversample_ratio_select;
		// 6,10,18,..,258 is 2+4*ratio; top entry is 512 not 514
		if (oversample_ratio_select == 3'h7) begin
			min_sample_interval_ms = 10'h200;
		end else begin
			min_sample_interval_ms = 10'(SAMPLE_BASE_MS - SAMPLE_STEP_MS)
				+ 10'(SAMPLE_STEP_MS) * {2'h0, oversample_ratio};
		end
	end

	// ms enable and interval spacing counter
	logic [14:0] ms_cnt_reg, ms_cnt_next;
	logic [9:0]  gap_reg, gap_next;
	logic        ms_tick;
	always_comb begin
		ms_tick    = (ms_cnt_reg == 15'(MS_CYCLES - 1));
		ms_cnt_next = ms_tick ? 15'h0000 : ms_cnt_reg + 15'h0001;
		gap_next   = gap_reg;
		if (sample_valid) begin
			gap_next = 10'h000;
		end else if (ms_tick && gap_reg != 10'h3ff) begin
			gap_next = gap_reg + 10'h001;
		end
		sample_slot_ready = (gap_reg >= min_sample_interval_ms);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ms_cnt_reg <= 15'h0000;
			gap_reg    <= 10'h3ff;
		end else begin
			ms_cnt_reg <= ms_cnt_next;
			gap_reg    <= gap_next;
		end
	end

	// ****************************************************
	// acquisition time step
	// ****************************************************
	// second prescaler, then seconds counted against 2^exponent
	logic [24:0] sec_cnt_reg, sec_cnt_next;
	logic [15:0] step_cnt_reg, step_cnt_next;
	logic        sec_tick;
	logic        tick_next;
	logic [15:0] step_len;
	always_comb begin
		// R06 step is two to n
		step_len      = 16'h0001 << acq_reg[3:0];
		sec_tick      = (sec_cnt_reg == 25'(SECOND_CYCLES - 1));
		sec_cnt_next  = sec_tick ? 25'h0000000 : sec_cnt_reg + 25'h0000001;
		step_cnt_next = step_cnt_reg;
		tick_next     = 1'b0;
		if (sec_tick) begin
			if (step_cnt_reg + 16'h0001 >= step_len) begin
				step_cnt_next = 16'h0000;
				tick_next     = 1'b1;
			end else begin
				step_cnt_next = step_cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sec_cnt_reg      <= 25'h0000000;
			step_cnt_reg     <= 16'h0000;
			acquisition_tick <= 1'b0;
		end else begin
			sec_cnt_reg      <= sec_cnt_next;
			step_cnt_reg     <= step_cnt_next;
			acquisition_tick <= tick_next;
		end
	end

	// ****************************************************
	// target capture
	// ****************************************************
	// a held load bit captures once; the host must toggle it to rearm
	apc_cap_state_t cap_reg, cap_next;
	logic [19:0]    cap_p_reg, cap_p_next;
	logic [11:0]    cap_t_reg, cap_t_next;
	always_comb begin
		cap_next   = cap_reg;
		cap_p_next = cap_p_reg;
		cap_t_next = cap_t_reg;
		case (cap_reg)
			APC_CAP_IDLE: begin
				if (acq_reg[LOAD_TARGET_BIT]) begin
					cap_next = APC_CAP_ARM;
				end
			end
			APC_CAP_ARM: begin
				// R02 capture next output
				if (!acq_reg[LOAD_TARGET_BIT]) begin
					cap_next = APC_CAP_IDLE;
				end else if (sample_valid) begin
					cap_p_next = pressure_output;
					cap_t_next = temperature_output;
					cap_next   = APC_CAP_DONE;
				end
			end
			default: begin
				// R03 rearm on clear
				if (!acq_reg[LOAD_TARGET_BIT]) begin
					cap_next = APC_CAP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cap_reg            <= APC_CAP_IDLE;
			cap_p_reg          <= 20'h00000;
			cap_t_reg          <= 12'h000;
			pressure_target    <= 20'h00000;
			temperature_target <= 12'h000;
		end else begin
			cap_reg   <= cap_next;
			cap_p_reg <= cap_p_next;
			cap_t_reg <= cap_t_next;
			// R05 target source select
			pressure_target    <= acq_reg[TARGET_SRC_BIT] ? cap_p_next
				: pressure_target_prog;
			temperature_target <= acq_reg[TARGET_SRC_BIT] ? cap_t_next
				: temperature_target_prog;
		end
	end

	// ****************************************************
	// interrupt pads
	// ****************************************************
	apc_pin_if pin_a ();
	apc_pin_if pin_b ();

	// R13 OR of routed sources
	assign pin_a.request = |irq_sources_a;
	assign pin_b.request = |irq_sources_b;
	// R07 pin A polarity
	assign pin_a.polarity   = irq_reg[IRQ_A_POL_BIT];
	// R08 pin A drive
	assign pin_a.open_drain = irq_reg[IRQ_A_OD_BIT];
	// R09 pin B polarity
	assign pin_b.polarity   = irq_reg[IRQ_B_POL_BIT];
	// R10 pin B drive
	assign pin_b.open_drain = irq_reg[IRQ_B_OD_BIT];

	// R14 open drain release
	apc_pin_driver u_pad_a (
		.clock   (clock),
		.reset_n (reset_n),
		.pin     (pin_a.pad)
	);
	apc_pin_driver u_pad_b (
		.clock   (clock),
		.reset_n (reset_n),
		.pin     (pin_b.pad)
	);

	assign irq_pin_a_out = pin_a.pad_out;
	assign irq_pin_a_oe  = pin_a.pad_oe;
	assign irq_pin_b_out = pin_b.pad_out;
	assign irq_pin_b_oe  = pin_b.pad_oe;
endmodule : apc_acq_ctrl

// [logic/apc_pkg.sv]
package apc_pkg;

	// ****************************************************
	// register offsets
	// ****************************************************
	localparam logic [7:0] SAMPLING_MODE_CONTROL_ADDR     = 8'h26;
	localparam logic [7:0] ACQUISITION_ALARM_CONTROL_ADDR = 8'h27;
	localparam logic [7:0] IRQ_PIN_CONTROL_ADDR           = 8'h28;

	// ****************************************************
	// field positions and reset values
	// ****************************************************
	localparam int OSR_LSB         = 3;
	localparam int LOAD_TARGET_BIT = 5;
	localparam int TARGET_SRC_BIT  = 4;
	localparam int IRQ_A_POL_BIT   = 5;
	localparam int IRQ_A_OD_BIT    = 4;
	localparam int IRQ_B_POL_BIT   = 1;
	localparam int IRQ_B_OD_BIT    = 0;
	localparam logic [7:0] SAMPLING_WRITE_MASK = 8'h38;
	localparam logic [7:0] ACQ_WRITE_MASK      = 8'h3f;
	localparam logic [7:0] IRQ_WRITE_MASK      = 8'h33;
	localparam logic [7:0] CTRL_RESET          = 8'h00;

	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLOCK_HZ        = 25_000_000;
	localparam int SAMPLE_BASE_MS  = 6;
	localparam int SAMPLE_STEP_MS  = 4;
	localparam int MS_CYCLES       = CLOCK_HZ / 1000;
	localparam int SECOND_CYCLES   = CLOCK_HZ;

	typedef enum logic [1:0] {
		APC_CAP_IDLE = 2'b00,
		APC_CAP_ARM  = 2'b01,
		APC_CAP_DONE = 2'b11
	} apc_cap_state_t;

endpackage : apc_pkg

// [logic/apc_pin_if.sv]
// one interrupt pad: merged request in, pad drive out
interface apc_pin_if;
	logic request;
	logic polarity;
	logic open_drain;
	logic pad_out;
	logic pad_oe;
	modport ctrl (output request, output polarity, output open_drain,
		input pad_out, input pad_oe);
	modport pad (input request, input polarity, input open_drain,
		output pad_out, output pad_oe);
endinterface : apc_pin_if

// [logic/apc_pin_driver.sv]
module apc_pin_driver (
	input  wire logic clock,
	input  wire logic reset_n,
	apc_pin_if.pad    pin
);
	import apc_pkg::*;

	logic level_next;
	logic level_reg;
	logic oe_next;
	logic oe_reg;

	// level follows polarity; open drain drives only when asserted
	always_comb begin
		level_next = pin.request ^ ~pin.polarity;
		oe_next    = pin.open_drain ? pin.request : 1'b1;
	end

	// pad flops; idle after reset is inactive low-polarity high
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			level_reg <= 1'b1;
			oe_reg    <= 1'b1;
		end else begin
			level_reg <= level_next;
			oe_reg    <= oe_next;
		end
	end

	assign pin.pad_out = level_reg;
	assign pin.pad_oe  = oe_reg;
endmodule : apc_pin_driver

// [sim/apc_acq_ctrl_monitor.sv]
module apc_acq_ctrl_monitor
	import apc_pkg::*;
(
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        reg_write,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        sample_valid,
	input wire logic [19:0] pressure_target,
	input wire logic [19:0] pressure_target_prog,
	input wire logic [2:0]  oversample_ratio_select,
	input wire logic [7:0]  oversample_ratio,
	input wire logic [9:0]  min_sample_interval_ms,
	input wire logic [7:0]  irq_sources_a,
	input wire logic [7:0]  irq_sources_b,
	input wire logic        irq_pin_a_out,
	input wire logic        irq_pin_a_oe,
	input wire logic        irq_pin_b_out,
	input wire logic        irq_pin_b_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// mirror of written config, checks
	// ****
	logic [7:0] acq_reg;
	logic [7:0] pin_reg;
	logic       req_a;
	logic       req_b;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// shadow copies, so pads are judged against host intent
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			acq_reg <= 8'h00;
			pin_reg <= 8'h00;
		end else if (reg_write &&
			reg_addr == ACQUISITION_ALARM_CONTROL_ADDR) begin
			acq_reg <= reg_wdata;
		end else if (reg_write && reg_addr == IRQ_PIN_CONTROL_ADDR) begin
			pin_reg <= reg_wdata;
		end
	end
	assign req_a = |irq_sources_a;
	assign req_b = |irq_sources_b;
	AST_OSR_RATIO: assert property (
		oversample_ratio == (8'h01 << oversample_ratio_select))
		else $error("oversample ratio wrong");
	AST_INTERVAL: assert property (
		min_sample_interval_ms == ((oversample_ratio_select == 3'h7) ?
		10'h200 : 10'h002 + (10'h004 << oversample_ratio_select)))
		else $error("sample interval wrong");
	AST_OSR_FIELD: assert property (
		reg_write && reg_addr == SAMPLING_MODE_CONTROL_ADDR |=>
		oversample_ratio_select == 3'($past(reg_wdata) >> 3))
		else $error("oversample field not taken");
	AST_RSV_HIGH: assert property (reg_rdata[7:6] == 2'b00)
		else $error("reserved high bits nonzero");
	AST_RSV_IRQ: assert property (
		reg_addr == IRQ_PIN_CONTROL_ADDR |=> reg_rdata[3:2] == 2'b00)
		else $error("reserved pin bits nonzero");
	AST_TGT_PROG: assert property (
		!acq_reg[4] |=> pressure_target == $past(pressure_target_prog))
		else $error("programmed target not used");
	AST_TGT_HOLD: assert property (
		acq_reg[4] && $past(acq_reg[4]) && !sample_valid &&
		!$past(sample_valid) |=> $stable(pressure_target))
		else $error("captured target moved");
	AST_PIN_A_LEVEL: assert property (
		irq_pin_a_out == ($past(req_a) ~^ $past(pin_reg[5])))
		else $error("pin a level wrong");
	AST_PIN_A_OE: assert property (
		irq_pin_a_oe == (!$past(pin_reg[4]) || $past(req_a)))
		else $error("pin a enable wrong");
	AST_PIN_B_LEVEL: assert property (
		irq_pin_b_out == ($past(req_b) ~^ $past(pin_reg[1])))
		else $error("pin b level wrong");
	AST_PIN_B_OE: assert property (
		irq_pin_b_oe == (!$past(pin_reg[0]) || $past(req_b)))
		else $error("pin b enable wrong");
endmodule // apc_acq_ctrl_monitor

bind apc_acq_ctrl apc_acq_ctrl_monitor i_monitor (.clock, .reset_n,
	.reg_write, .reg_addr, .reg_wdata, .reg_rdata, .sample_valid,
	.pressure_target, .pressure_target_prog, .oversample_ratio_select,
	.oversample_ratio, .min_sample_interval_ms, .irq_sources_a,
	.irq_sources_b, .irq_pin_a_out, .irq_pin_a_oe, .irq_pin_b_out,
	.irq_pin_b_oe);

// [sim/apc_sample_source.sv]
module apc_sample_source (
	input  wire logic        clock,
	output logic             sample_valid,
	output logic      [19:0] pressure_output,
	output logic      [11:0] temperature_output
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// measurement side model
	// ****
	initial begin
		sample_valid = 1'b0;
		pressure_output = 20'h00000;
		temperature_output = 12'h000;
	end
	// outputs invert after the pulse so stale data is never reused
	task emit(input logic [19:0] p, input logic [11:0] t);
		@(negedge clock);
		sample_valid = 1'b1;
		pressure_output = p;
		temperature_output = t;
		@(negedge clock);
		sample_valid = 1'b0;
		pressure_output = ~p;
		temperature_output = ~t;
	endtask
endmodule // apc_sample_source

// [sim/tb_acq_and_irq_pin_control.sv]
module tb_acq_and_irq_pin_control;
	import apc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// bench
	// ****
	logic        clock, reset_n, reg_write, sample_valid, sample_slot_ready;
	logic        acquisition_tick, irq_pin_a_out, irq_pin_a_oe;
	logic        irq_pin_b_out, irq_pin_b_oe;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, oversample_ratio;
	logic [7:0]  irq_sources_a, irq_sources_b;
	logic [19:0] pressure_output, pressure_target_prog, pressure_target;
	logic [11:0] temperature_output, temperature_target_prog;
	logic [11:0] temperature_target;
	logic [2:0]  oversample_ratio_select;
	logic [9:0]  min_sample_interval_ms;
	int          miscompares = 0;
	int          checked = 0;

	apc_acq_ctrl i_dut (.clock, .reset_n, .reg_write, .reg_addr,
		.reg_wdata, .reg_rdata, .sample_valid, .pressure_output,
		.temperature_output, .pressure_target_prog,
		.temperature_target_prog, .pressure_target, .temperature_target,
		.oversample_ratio_select, .oversample_ratio,
		.min_sample_interval_ms, .sample_slot_ready, .acquisition_tick,
		.irq_sources_a, .irq_sources_b, .irq_pin_a_out, .irq_pin_a_oe,
		.irq_pin_b_out, .irq_pin_b_oe);
	apc_sample_source i_src (.clock, .sample_valid, .pressure_output,
		.temperature_output);

	always #20 clock = ~clock;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
	endtask
	// registered read data, one cycle after the address
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		@(negedge clock);
		chk(reg_rdata, e);
	endtask
	task close_out;
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// reset values, writable masks, unmapped place
	task t_regs;
		// a step is a second at least, far beyond this run
		chk(acquisition_tick, 1'b0);
		rd_chk(ACQUISITION_ALARM_CONTROL_ADDR, 8'h00);
		rd_chk(IRQ_PIN_CONTROL_ADDR, 8'h00);
		wr(SAMPLING_MODE_CONTROL_ADDR, 8'hff);
		rd_chk(SAMPLING_MODE_CONTROL_ADDR, 8'h38);
		wr(ACQUISITION_ALARM_CONTROL_ADDR, 8'hff);
		rd_chk(ACQUISITION_ALARM_CONTROL_ADDR, 8'h3f);
		wr(IRQ_PIN_CONTROL_ADDR, 8'hff);
		rd_chk(IRQ_PIN_CONTROL_ADDR, 8'h33);
		wr(8'h29, 8'hff);
		rd_chk(8'h29, 8'h00);
		wr(ACQUISITION_ALARM_CONTROL_ADDR, 8'h00);
	endtask
	task automatic t_ratio;
		int i;
		int tbl[8] = '{6, 10, 18, 34, 66, 130, 258, 512};
		for (i = 0; i < 8; i++) begin
			wr(SAMPLING_MODE_CONTROL_ADDR, 8'(i << 3));
			chk(oversample_ratio_select, i);
			chk(oversample_ratio, 8'h01 << i);
			chk(min_sample_interval_ms, tbl[i]);
		end
	endtask
	// every polarity and drive mode, idle and active request
	task t_pins;
		int c;
		for (c = 0; c < 64; c++) begin
			wr(IRQ_PIN_CONTROL_ADDR, {2'b00, c[0], c[1], 2'b00, c[2], c[3]});
			irq_sources_a = c[4] ? 8'h41 : 8'h00;
			irq_sources_b = c[5] ? 8'h80 : 8'h00;
			@(negedge clock);
			chk(irq_pin_a_out, c[4] == c[0]);
			chk(irq_pin_a_oe, !c[1] || c[4]);
			chk(irq_pin_b_out, c[5] == c[2]);
			chk(irq_pin_b_oe, !c[3] || c[5]);
		end
		// other source bits, both pins active high open drain
		irq_sources_a = 8'h08;
		irq_sources_b = 8'h02;
		@(negedge clock);
		chk(irq_pin_a_out, 1'b1);
		chk(irq_pin_b_oe, 1'b1);
		irq_sources_a = 8'h00;
		irq_sources_b = 8'h00;
		@(negedge clock);
		chk(irq_pin_a_oe, 1'b0);
		chk(irq_pin_b_oe, 1'b0);
	endtask
	task t_targets;
		pressure_target_prog = 20'h12345;
		temperature_target_prog = 12'h678;
		repeat (2) @(negedge clock);
		chk({pressure_target, temperature_target}, 32'h12345678);
		wr(ACQUISITION_ALARM_CONTROL_ADDR, 8'h30);
		repeat (3) @(negedge clock);
		chk(sample_slot_ready, 1'b1);
		i_src.emit(20'habcde, 12'hf01);
		repeat (2) @(negedge clock);
		chk({pressure_target, temperature_target}, 32'habcdef01);
		chk(sample_slot_ready, 1'b0);
		i_src.emit(20'h11111, 12'h222);
		repeat (2) @(negedge clock);
		chk({pressure_target, temperature_target}, 32'habcdef01);
		wr(ACQUISITION_ALARM_CONTROL_ADDR, 8'h10);
		wr(ACQUISITION_ALARM_CONTROL_ADDR, 8'h30);
		repeat (3) @(negedge clock);
		i_src.emit(20'h33333, 12'h444);
		repeat (2) @(negedge clock);
		chk({pressure_target, temperature_target}, 32'h33333444);
		wr(ACQUISITION_ALARM_CONTROL_ADDR, 8'h00);
		repeat (2) @(negedge clock);
		chk({pressure_target, temperature_target}, 32'h12345678);
	endtask

	// main sequence, reset held for twenty cycles
	initial begin
		clock = 1'b0;
		reset_n = 1'b0;
		reg_write = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		irq_sources_a = 8'h00;
		irq_sources_b = 8'h00;
		pressure_target_prog = 20'h00000;
		temperature_target_prog = 12'h000;
		repeat (20) @(posedge clock);
		@(negedge clock);
		reset_n = 1'b1;
		t_regs;
		t_ratio;
		t_pins;
		t_targets;
		close_out;
	end
	// about 280 cycles expected; generous margin
	initial begin
		#200_000;
		miscompares++;
		close_out;
	end
endmodule // tb_acq_and_irq_pin_control
